// ==== rtl/cfg_loader_pkg.sv ====
// constants shared by the configuration word loader and its fetcher
package cfg_loader_pkg;
    // sizes of the loaded map
    localparam int NUM_PORTS = 4;
    localparam int NUM_FUNCS = 3;
    localparam int NUM_WORDS = 10;

    // nonvolatile word addresses
    localparam logic [7:0] W_FIRST = 8'h4c;
    localparam logic [7:0] W_STEP = 8'h02;
    localparam logic [7:0] W_REV_F2 = 8'h4c;
    localparam logic [7:0] W_USB1 = 8'h4e;
    localparam logic [7:0] W_PM_BASE = 8'h50;
    localparam logic [7:0] W_CLASS_BASE = 8'h58;
    localparam logic [7:0] W_USB2 = 8'h5e;

    // bit positions inside a power-management word
    localparam int PW_NSR = 0;
    localparam int PW_AUX_LSB = 1;
    localparam int PW_D1 = 4;
    localparam int PW_D2 = 5;
    localparam int PW_PME_LSB = 6;
    localparam int PW_DATA_LSB = 8;

    // field positions in the config images
    localparam int CAP_AUX_LSB = 22;
    localparam int CAP_D1 = 25;
    localparam int CAP_D2 = 26;
    localparam int CAP_PME_LSB = 28;
    localparam int CSR_NSR = 3;
    localparam int CSR_DATA_LSB = 24;
    localparam int CC_REV_LSB = 0;
    localparam int CC_PROG_LSB = 8;
    localparam int CC_SUB_LSB = 16;
    localparam int CC_BASE_LSB = 24;

    // apb byte addresses
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_CLASS_BASE = 12'h010;
    localparam logic [11:0] A_USB1 = 12'h020;
    localparam logic [11:0] A_USB2 = 12'h024;
    localparam logic [11:0] A_PMCAP_BASE = 12'h030;
    localparam logic [11:0] A_PMCSR_BASE = 12'h040;
    localparam logic [11:0] A_STRIDE = 12'h004;

    // control register bits
    localparam int CTRL_RELOAD = 0;
    localparam int CTRL_VALID = 1;
    localparam int CTRL_BUSY = 2;

    // values after reset
    localparam logic RST_D_SUPPORT = 1'b1;
    localparam logic RST_START = 1'b1;
endpackage

// ==== rtl/cfg_word_if.sv ====
// handshake between the word fetcher and the field loader
`timescale 1ns/1ps
interface cfg_word_if;
    logic start;
    logic wvalid;
    logic [7:0] waddr;
    logic [15:0] wdata;
    logic done;
    modport fetch(input start, output wvalid, output waddr, output wdata, output done);
    modport sink(output start, input wvalid, input waddr, input wdata, input done);
endinterface

// ==== rtl/word_fetcher.sv ====
// walks the nonvolatile word addresses and hands each word on
`timescale 1ns/1ps
module word_fetcher (
    input wire logic pclk,
    input wire logic presetn,
    cfg_word_if.fetch ld,
    output logic nv_rd_req,
    output logic [7:0] nv_addr,
    input wire logic [15:0] nv_rdata,
    input wire logic nv_rd_ack
);
    typedef enum logic [1:0] {IDLE, REQ, GAP} fetch_state_t;
    typedef struct packed {
        fetch_state_t st;
        logic [3:0] idx;
        logic req;
        logic [7:0] addr;
        logic wvalid;
        logic [15:0] wdata;
        logic done;
    } fetch_t;

    fetch_t r;
    fetch_t r_nxt;

    // next state: one word per request, one idle cycle between words
    always_comb begin
        r_nxt = r;
        r_nxt.wvalid = 1'b0;
        r_nxt.done = 1'b0;
        case (r.st)
            IDLE: begin
                if (ld.start) begin
                    r_nxt.st = REQ;
                    r_nxt.idx = 4'h0;
                    r_nxt.addr = cfg_loader_pkg::W_FIRST;
                    r_nxt.req = 1'b1;
                end
            end
            REQ: begin
                if (nv_rd_ack) begin
                    r_nxt.req = 1'b0;
                    r_nxt.wvalid = 1'b1;
                    r_nxt.wdata = nv_rdata;
                    if (r.idx == 4'(cfg_loader_pkg::NUM_WORDS - 1)) begin
                        r_nxt.st = IDLE;
                        r_nxt.done = 1'b1;
                    end else begin
                        r_nxt.st = GAP;
                    end
                end
            end
            GAP: begin
                r_nxt.st = REQ;
                r_nxt.idx = r.idx + 4'h1;
                r_nxt.addr = r.addr + cfg_loader_pkg::W_STEP;
                r_nxt.req = 1'b1;
            end
            default: r_nxt.st = IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: IDLE, default: '0};
        end else begin
            r <= r_nxt;
        end
    end

    assign nv_rd_req = r.req;
    assign nv_addr = r.addr;
    assign ld.wvalid = r.wvalid;
    assign ld.waddr = r.addr; // still the word just answered
    assign ld.wdata = r.wdata;
    assign ld.done = r.done;
endmodule

// ==== rtl/config_word_loader.sv ====
// loads configuration words 4ch..5eh into config fields, apb view of them
`timescale 1ns/1ps
module config_word_loader (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic nv_rd_req,
    output logic [7:0] nv_addr,
    input wire logic [15:0] nv_rdata,
    input wire logic nv_rd_ack,
    output logic cfg_valid
);
    localparam int NP = cfg_loader_pkg::NUM_PORTS;
    localparam int NF = cfg_loader_pkg::NUM_FUNCS;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic start;
        logic busy;
        logic valid;
        logic [7:0] rev_f2;
        logic [7:0] prog_f2;
        logic [NF-1:0][7:0] sub;
        logic [NF-1:0][7:0] base;
        logic [15:0] usb1;
        logic [15:0] usb2;
        logic [NP-1:0][2:0] aux;
        logic [NP-1:0] d1;
        logic [NP-1:0] d2;
        logic [NP-1:0][1:0] pme;
        logic [NP-1:0] nsr;
        logic [NP-1:0][7:0] pmdata;
    } loader_t;

    loader_t r;
    loader_t r_nxt;
    cfg_word_if ld();

    word_fetcher u_fetch (
        .pclk(pclk),
        .presetn(presetn),
        .ld(ld),
        .nv_rd_req(nv_rd_req),
        .nv_addr(nv_addr),
        .nv_rdata(nv_rdata),
        .nv_rd_ack(nv_rd_ack)
    );

    // register read decode, bit 32 flags a mapped address
    function automatic logic [32:0] reg_read(input logic [11:0] a, input loader_t s);
        logic [32:0] v;
        v = '0;
        if (a == cfg_loader_pkg::A_CTRL) begin
            v[32] = 1'b1;
            v[cfg_loader_pkg::CTRL_VALID] = s.valid;
            v[cfg_loader_pkg::CTRL_BUSY] = s.busy;
        end
        if (a == cfg_loader_pkg::A_USB1) begin
            v = {1'b1, 16'h0000, s.usb1};
        end
        if (a == cfg_loader_pkg::A_USB2) begin
            v = {1'b1, 16'h0000, s.usb2};
        end
        for (int f = 0; f < NF; f++) begin
            if (a == cfg_loader_pkg::A_CLASS_BASE + 12'(f * 4)) begin
                v[32] = 1'b1;
                v[cfg_loader_pkg::CC_SUB_LSB +: 8] = s.sub[f];
                v[cfg_loader_pkg::CC_BASE_LSB +: 8] = s.base[f];
                if (f == NF - 1) begin
                    v[cfg_loader_pkg::CC_REV_LSB +: 8] = s.rev_f2;
                    v[cfg_loader_pkg::CC_PROG_LSB +: 8] = s.prog_f2;
                end
            end
        end
        for (int p = 0; p < NP; p++) begin
            if (a == cfg_loader_pkg::A_PMCAP_BASE + 12'(p * 4)) begin
                v[32] = 1'b1;
                v[cfg_loader_pkg::CAP_AUX_LSB +: 3] = s.aux[p];
                v[cfg_loader_pkg::CAP_D1] = s.d1[p];
                v[cfg_loader_pkg::CAP_D2] = s.d2[p];
                v[cfg_loader_pkg::CAP_PME_LSB +: 2] = s.pme[p];
            end
            if (a == cfg_loader_pkg::A_PMCSR_BASE + 12'(p * 4)) begin
                v[32] = 1'b1;
                v[cfg_loader_pkg::CSR_NSR] = s.nsr[p];
                v[cfg_loader_pkg::CSR_DATA_LSB +: 8] = s.pmdata[p];
            end
        end
        return v;
    endfunction

    // next state: apb slave, reload control and word-to-field mapping
    always_comb begin
        logic [32:0] rd;
        rd = reg_read(paddr, r);
        r_nxt = r;
        r_nxt.start = 1'b0;
        // answer one cycle after the setup cycle
        r_nxt.pready = psel && !penable;
        if (psel && !penable) begin
            r_nxt.pslverr = !rd[32];
            r_nxt.prdata = pwrite ? 32'h0000_0000 : rd[31:0];
        end
        // reload request, ignored while a load runs
        if (psel && penable && r.pready && pwrite && paddr == cfg_loader_pkg::A_CTRL
                && pwdata[cfg_loader_pkg::CTRL_RELOAD] && !r.busy) begin
            r_nxt.start = 1'b1;
            r_nxt.busy = 1'b1;
            r_nxt.valid = 1'b0;
        end
        if (ld.wvalid) begin
            if (ld.waddr == cfg_loader_pkg::W_REV_F2) begin
                r_nxt.rev_f2 = ld.wdata[7:0];
                r_nxt.prog_f2 = ld.wdata[15:8];
            end
            if (ld.waddr == cfg_loader_pkg::W_USB1) begin
                r_nxt.usb1 = ld.wdata;
            end
            if (ld.waddr == cfg_loader_pkg::W_USB2) begin
                r_nxt.usb2 = ld.wdata;
            end
            for (int p = 0; p < NP; p++) begin
                if (ld.waddr == cfg_loader_pkg::W_PM_BASE + 8'(p * 2)) begin
                    r_nxt.nsr[p] = ld.wdata[cfg_loader_pkg::PW_NSR];
                    r_nxt.aux[p] = ld.wdata[cfg_loader_pkg::PW_AUX_LSB +: 3];
                    r_nxt.d1[p] = ld.wdata[cfg_loader_pkg::PW_D1];
                    r_nxt.d2[p] = ld.wdata[cfg_loader_pkg::PW_D2];
                    r_nxt.pme[p] = ld.wdata[cfg_loader_pkg::PW_PME_LSB +: 2];
                    r_nxt.pmdata[p] = ld.wdata[cfg_loader_pkg::PW_DATA_LSB +: 8];
                end
            end
            for (int f = 0; f < NF; f++) begin
                if (ld.waddr == cfg_loader_pkg::W_CLASS_BASE + 8'(f * 2)) begin
                    r_nxt.sub[f] = ld.wdata[7:0];
                    r_nxt.base[f] = ld.wdata[15:8];
                end
            end
        end
        // last word handed over: fields become valid
        if (ld.done) begin
            r_nxt.valid = 1'b1;
            r_nxt.busy = 1'b0;
        end
    end

    // state register; a load starts by itself after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.start <= cfg_loader_pkg::RST_START;
            r.busy <= cfg_loader_pkg::RST_START;
            r.d1 <= {NP{cfg_loader_pkg::RST_D_SUPPORT}};
            r.d2 <= {NP{cfg_loader_pkg::RST_D_SUPPORT}};
        end else begin
            r <= r_nxt;
        end
    end

    assign ld.start = r.start;
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign cfg_valid = r.valid;

    // checks on the loaded fields, the valid and busy flags and the apb answer timing
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rev_f2;
        ld.wvalid && ld.waddr == 8'h4c |=>
            r.rev_f2 == $past(ld.wdata[7:0]) && r.prog_f2 == $past(ld.wdata[15:8]);
    endproperty
    a_rev_f2: assert property (p_rev_f2) else $error("f2 revision not loaded");

    property p_usb1;
        ld.wvalid && ld.waddr == 8'h4e |=> r.usb1 == $past(ld.wdata);
    endproperty
    a_usb1: assert property (p_usb1) else $error("usb phy 1 not loaded");

    property p_nsr3;
        ld.wvalid && ld.waddr == 8'h56 |=> r.nsr[3] == $past(ld.wdata[0]) && $stable(r.nsr[2:0]);
    endproperty
    a_nsr3: assert property (p_nsr3) else $error("port 3 soft reset skip wrong");

    property p_aux1;
        ld.wvalid && ld.waddr == 8'h52 |=> r.aux[1] == $past(ld.wdata[3:1]);
    endproperty
    a_aux1: assert property (p_aux1) else $error("port 1 aux current wrong");

    property p_dsup0;
        ld.wvalid && ld.waddr == 8'h50 |=>
            r.d1[0] == $past(ld.wdata[4]) && r.d2[0] == $past(ld.wdata[5]);
    endproperty
    a_dsup0: assert property (p_dsup0) else $error("port 0 d1/d2 support wrong");

    property p_pme2;
        ld.wvalid && ld.waddr == 8'h54 |=> r.pme[2] == $past(ld.wdata[7:6]);
    endproperty
    a_pme2: assert property (p_pme2) else $error("port 2 pme support wrong");

    property p_pmdata0;
        ld.wvalid && ld.waddr == 8'h50 |=> r.pmdata[0] == $past(ld.wdata[15:8]);
    endproperty
    a_pmdata0: assert property (p_pmdata0) else $error("port 0 pm data wrong");

    property p_class1;
        ld.wvalid && ld.waddr == 8'h5a |=>
            r.sub[1] == $past(ld.wdata[7:0]) && r.base[1] == $past(ld.wdata[15:8]);
    endproperty
    a_class1: assert property (p_class1) else $error("function 1 class wrong");

    property p_usb2;
        ld.wvalid && ld.waddr == 8'h5e |=> r.usb2 == $past(ld.wdata);
    endproperty
    a_usb2: assert property (p_usb2) else $error("usb phy 2 not loaded");

    property p_valid_after_done;
        ld.done |=> cfg_valid ##0 !r.busy;
    endproperty
    a_valid_after_done: assert property (p_valid_after_done) else $error("valid late");

    property p_no_valid_while_loading;
        ld.wvalid |-> !cfg_valid && r.busy;
    endproperty
    a_no_valid_while_loading: assert property (p_no_valid_while_loading)
        else $error("valid during load");

    property p_apb_answer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

    c_load_done: cover property (ld.done);
    c_apb_read: cover property (psel && penable && pready && !pwrite && !pslverr);
    c_reload: cover property (cfg_valid ##1 r.start && !cfg_valid);
    c_unmapped: cover property (psel && penable && pready && pslverr);
endmodule

// ==== test/nv_store_model.sv ====
// behavioural nonvolatile word storage answering the loader
`timescale 1ns/1ps
module nv_store_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic nv_rd_req,
    input wire logic [7:0] nv_addr,
    input wire logic [9:0][15:0] words,
    input wire logic [7:0] delay,
    output logic [15:0] nv_rdata,
    output logic nv_rd_ack
);
    logic [7:0] wait_r;
    logic [7:0] idx;

    // word slot from the even word address
    assign idx = (nv_addr - 8'h4c) >> 1;

    // one-cycle answer after delay cycles; data line churns when not answering
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_rd_ack <= 1'b0;
            wait_r <= 8'h00;
            nv_rdata <= 16'h5a5a;
        end else if (nv_rd_req && !nv_rd_ack && wait_r >= delay) begin
            nv_rd_ack <= 1'b1;
            nv_rdata <= words[idx[3:0]];
            wait_r <= 8'h00;
        end else begin
            nv_rd_ack <= 1'b0;
            nv_rdata <= ~nv_rdata;
            wait_r <= (nv_rd_req && !nv_rd_ack) ? wait_r + 8'h01 : 8'h00;
        end
    end
endmodule

// ==== test/test_config_word_loader.sv ====
// self-checking bench for the configuration word loader
`timescale 1ns/1ps
module test_config_word_loader;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] e;
    } row_t;
    localparam logic [9:0][15:0] SET1 = {16'hc3d4, 16'h0c07, 16'h0603, 16'h0106,
        16'h447e, 16'h33b9, 16'h2235, 16'h11f3, 16'h9a5b, 16'h30a1};
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic nv_rd_req;
    logic [7:0] nv_addr;
    logic [15:0] nv_rdata;
    logic nv_rd_ack;
    logic cfg_valid;
    logic [9:0][15:0] words;
    logic [7:0] delay;
    logic [31:0] rd;
    logic err;
    row_t rows [13];
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int nidx = 0;

    config_word_loader config_word_loader_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nv_rd_req(nv_rd_req), .nv_addr(nv_addr),
        .nv_rdata(nv_rdata), .nv_rd_ack(nv_rd_ack), .cfg_valid(cfg_valid));
    nv_store_model nv_store_model_i (.pclk(pclk), .presetn(presetn), .nv_rd_req(nv_rd_req),
        .nv_addr(nv_addr), .words(words), .delay(delay), .nv_rdata(nv_rdata),
        .nv_rd_ack(nv_rd_ack));

    // clock and hang guard
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // values read here are those sampled at this edge; the hang guard ends a lost answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        while (cfg_valid !== 1'b1 && n < 1000) begin
            @(negedge pclk);
            n++;
        end
        check("cfg_valid", {31'h0, cfg_valid}, 32'h1);
    endtask

    // expected images from the stored words, then one read per row
    task automatic check_all();
        for (int i = 0; i < 13; i++) begin
            if (i < 3)
                rows[i] = {12'h010 + 12'(4 * i), words[6 + i], (i == 2) ? words[0] : 16'h0};
            else if (i < 5)
                rows[i] = {(i == 3) ? 12'h020 : 12'h024, 16'h0, words[(i == 3) ? 1 : 9]};
            else if (i < 9)
                rows[i] = {12'h030 + 12'(4 * (i - 5)), 2'h0, words[i - 3][7:6], 1'b0,
                    words[i - 3][5:4], words[i - 3][3:1], 22'h0};
            else
                rows[i] = {12'h040 + 12'(4 * (i - 9)), words[i - 7][15:8], 20'h0,
                    words[i - 7][0], 3'h0};
        end
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            check("field image", rd, rows[i].e);
        end
    endtask

    // storage requests come in word order
    always @(negedge pclk) begin
        if (!presetn) begin
            nidx = 0;
        end else if (nv_rd_req && nv_rd_ack) begin
            check("nv_addr", {24'h0, nv_addr}, {24'h0, 8'h4c + 8'(2 * nidx)});
            nidx = (nidx + 1) % 10;
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        delay = 8'h14;
        words = SET1;
        repeat (10) @(posedge pclk);
        check("cfg_valid", {31'h0, cfg_valid}, 32'h0);
        check("nv_rd_req", {31'h0, nv_rd_req}, 32'h0);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        // reset images while the slow first load runs
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl busy", rd, 32'h4);
        apb(1'b0, 12'h030, 32'h0);
        check("pmcap0 reset", rd, 32'h0600_0000);
        apb(1'b0, 12'h010, 32'h0);
        check("class0 reset", rd, 32'h0);
        delay <= 8'h00;
        wait_valid();
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl done", rd, 32'h2);
        check_all();
        // read-only data field ignores writes; unmapped place errs
        apb(1'b1, 12'h040, 32'hffff_ffff);
        apb(1'b0, 12'h040, 32'h0);
        check("pmcsr0 kept", rd, rows[9].e);
        apb(1'b0, 12'h0fc, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        // reload with new words, second request while busy
        words <= ~SET1;
        delay <= 8'h03;
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl reload", rd, 32'h4);
        wait_valid();
        check_all();
        // reset in mid-load, then a full slow load
        apb(1'b1, 12'h000, 32'h1);
        repeat (5) @(posedge pclk);
        presetn <= 1'b0;
        delay <= 8'h14;
        @(posedge pclk);
        check("cfg_valid", {31'h0, cfg_valid}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 12'h030, 32'h0);
        check("pmcap0 reset", rd, 32'h0600_0000);
        wait_valid();
        check_all();
        give_verdict();
    end
endmodule
